// File: tb/tb_top.sv
`default_nettype none
// random events, masks and clears checked against an integer model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LD[4] = '{4, 6, 8, 10};
	localparam int SB[10] = '{0, 1, 2, 3, 3, 4, 5, 4, 5, 6};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic warn = 1'b0;
	logic [1:0] sel = 2'b00;
	logic [3:0] enp = 4'h0;
	logic irq_n, irq_oe, go;
	logic [7:0] rdata, d, m, e, c;
	tlia_pkg::tlia_req_t req;
	tlia_pkg::tlia_bits_t ev = '0;
	tlia_pkg::tlia_bits_t live = '0;
	int n_fail = 0;
	int check_count = 0;
	int g;
	int flag[10];
	int mask[10];
	// core clock
	always #5 clk = ~clk;
	tlia_top #(.LEAD0_CYC(LD[0]), .LEAD1_CYC(LD[1]), .LEAD2_CYC(LD[2]), .LEAD3_CYC(LD[3]))
	i_tlia_top (.MCLK_I(clk), .RST_B_I(rst_b), .REQ_I(req), .EVENT_I(ev), .LIVE_I(live),
		.ENABLE_PIN_LEVELS_I(enp), .EARLY_WARN_REQ_I(warn), .WARNING_LEAD_TIME_SEL_I(sel),
		.RDATA_O(rdata), .IRQ_OUT_N_O(irq_n), .IRQ_OUT_N_OE_O(irq_oe), .SHUTDOWN_GO_O(go));
	tlia_host i_tlia_host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rchk(input string what, input int a, input logic [7:0] exp);
		i_tlia_host.rd(5'(a), d);
		chk(what, d, exp);
	endtask : rchk
	// expected summary from the model's latches and masks
	function automatic logic [7:0] sum_exp(input logic w);
		logic [7:0] s;
		s = {w, 7'h00};
		for (int k = 0; k < 10; k++)
			if ((flag[k] & ~mask[k] & 255) != 0)
				s[SB[k]] = 1'b1;
		return s;
	endfunction : sum_exp
	task automatic chk_sum(input logic w);
		logic [7:0] s;
		s = sum_exp(w);
		chk("irq", {7'h00, irq_n}, {7'h00, s == 0});
		chk("irq_oe", {7'h00, irq_oe}, {7'h00, s != 0});
		rchk("summary", tlia_pkg::IDX_SUMMARY, s);
	endtask : chk_sum
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (int k = 0; k < 10; k++)
		begin
			flag[k] = 0;
			mask[k] = tlia_pkg::MASK_RESET & tlia_pkg::FLAG_VALID[k];
		end
	endtask : do_reset
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// main sequence
	initial
	begin
		void'($urandom(32'h0f4f_ee89));
		do_reset();
		for (int k = 0; k < 10; k++)
		begin
			rchk("mask", k * 3 + 1, 8'(mask[k]));
			rchk("latch", k * 3, 8'h00);
		end
		chk_sum(1'b0);
		repeat (40)
		begin
			g = $urandom_range(9);
			m = 8'($urandom);
			e = 8'($urandom);
			c = 8'($urandom);
			i_tlia_host.wr(5'(g * 3 + 1), m);
			mask[g] = m & tlia_pkg::FLAG_VALID[g];
			@(posedge clk);
			ev.grp[g] <= e;
			live.grp[g] <= e ^ c;
			enp <= c[3:0];
			@(posedge clk);
			ev <= '0;
			#1;
			flag[g] |= e & tlia_pkg::FLAG_VALID[g];
			chk_sum(1'b0);
			i_tlia_host.wr(tlia_pkg::IDX_SUMMARY, c);
			i_tlia_host.wr(5'(g * 3 + 2), c);
			rchk("latch", g * 3, 8'(flag[g]));
			rchk("mask", g * 3 + 1, 8'(mask[g]));
			rchk("live", g * 3 + 2, (e ^ c) & tlia_pkg::LIVE_VALID[g]);
			rchk("pins", tlia_pkg::IDX_ENABLE_PINS, {4'h0, c[3:0]});
			i_tlia_host.wr(5'(g * 3), c);
			flag[g] &= ~c;
			chk_sum(1'b0);
		end
		// event and write-one clear in one cycle: the event wins
		i_tlia_host.wr(5'h01, 8'h00);
		mask[0] = 0;
		fork
			i_tlia_host.wr(5'h00, 8'hFF);
			begin
				@(posedge clk);
				ev.grp[0] <= 8'h01;
				@(posedge clk);
				ev <= '0;
			end
		join
		flag[0] = 1;
		rchk("set beats clear", 0, 8'h01);
		chk_sum(1'b0);
		for (int k = 0; k < 4; k++)
		begin
			do_reset();
			@(posedge clk);
			warn <= 1'b1;
			sel <= 2'(k);
			@(posedge clk);
			warn <= 1'b0;
			#1;
			chk("irq warn", {7'h00, irq_n}, 8'h00);
			repeat (LD[k] - 1) @(posedge clk);
			#1 chk("go early", {7'h00, go}, 8'h00);
			@(posedge clk);
			#1 chk("go", {7'h00, go}, 8'h01);
			chk_sum(1'b1);
		end
		end_of_test();
	end
	// watchdog against a hung handshake
	initial
	begin
		repeat (50000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire

// File: tb/tlia_host.sv
`default_nettype none
// host side of the register port; requests launch and release on rising edges
module tlia_host (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output var tlia_pkg::tlia_req_t req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_o = '0;
	// one write cycle; a one clears a latch, a zero leaves it
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk_i);
		req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge clk_i);
		req_o <= '0;
		#1;
	endtask : wr
	// one read cycle; data settles just after the taking edge
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge clk_i);
		req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		req_o <= '0;
		#1 v = rdata_i;
	endtask : rd
endmodule : tlia_host
`default_nettype wire

// File: verilog/tlia_pkg.sv
`default_nettype none
package tlia_pkg;
	// group numbering used for latch, mask and live arrays
	localparam int NUM_GRP = 10;
	localparam int GRP_GENERAL = 0;
	localparam int GRP_TEMP = 1;
	localparam int GRP_MODE = 2;
	localparam int GRP_CONV_OC = 3;
	localparam int GRP_LIN_OC = 4;
	localparam int GRP_CONV_UV = 5;
	localparam int GRP_CONV_OV = 6;
	localparam int GRP_LIN_UV = 7;
	localparam int GRP_LIN_OV = 8;
	localparam int GRP_BUTTON = 9;
	// register index map: group g latch at 3g, mask at 3g+1, live at 3g+2
	localparam int ADDR_W = 5;
	localparam logic [4:0] IDX_ENABLE_PINS = 5'h1E;
	localparam logic [4:0] IDX_SUMMARY = 5'h1F;
	// implemented bit positions, group 9 first
	localparam logic [9:0][7:0] FLAG_VALID = {
		8'hFF, 8'h01, 8'h01, 8'h43, 8'h43, 8'h01, 8'h43, 8'h43, 8'hFF, 8'hFB};
	localparam logic [9:0][7:0] LIVE_VALID = {
		8'h81, 8'h01, 8'h01, 8'h43, 8'h43, 8'h01, 8'h43, 8'h00, 8'hFF, 8'h03};
	localparam logic [7:0] ENABLE_PIN_VALID = 8'h0F;
	localparam logic [7:0] MASK_RESET = 8'hFF;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	// summary bit positions
	localparam int SUM_GENERAL = 0;
	localparam int SUM_SECOND = 1;
	localparam int SUM_MODE = 2;
	localparam int SUM_OC = 3;
	localparam int SUM_UV = 4;
	localparam int SUM_OV = 5;
	localparam int SUM_BUTTON = 6;
	localparam int SUM_WARN = 7;
	// warning lead times and their cycle counts at the core clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int LEAD0_US = 100;
	localparam int LEAD1_US = 5000;
	localparam int LEAD2_MS = 20;
	localparam int LEAD3_MS = 50;
	localparam int LEAD0_CYC = LEAD0_US * 1000 / CLK_PERIOD_NS;
	localparam int LEAD1_CYC = LEAD1_US * 1000 / CLK_PERIOD_NS;
	localparam int LEAD2_CYC = LEAD2_MS * 1000000 / CLK_PERIOD_NS;
	localparam int LEAD3_CYC = LEAD3_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W = 23;
	localparam logic [22:0] CNT_RESET = 23'h00_0000;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [7:0] wdata;
	} tlia_req_t;

	typedef struct packed {
		logic [9:0][7:0] grp;
	} tlia_bits_t;

	typedef struct packed {
		logic [9:0][7:0] flag;
		logic [9:0][7:0] mask;
		logic [7:0] summary;
		logic irq_n;
		logic irq_oe;
		logic [7:0] rdata;
		logic warn_run;
		logic [22:0] warn_cnt;
		logic go;
	} tlia_state_t;
endpackage : tlia_pkg
`default_nettype wire

// File: verilog/tlia_top.sv
`default_nettype none
// Overview of operation
// - summary register points to pending second-level group
// - summary bit0: general group unmasked pending
// - summary bit1: second general group pending
// - summary bit2: converter mode group pending
// - summary bit3: any unmasked overcurrent latch
// - summary bit4: any unmasked undervoltage latch
// - summary bit5: any unmasked overvoltage latch
// - summary bit6: push-button group pending
// - summary bit7: early warning, selectable lead
// - summary bits 0-6 need latch set and unmasked; bit7 is set by the warning request
// - summary bits 0-6 clear themselves when latches clear; bit7 holds until reset
// - interrupt low while any summary bit
// - same bit positions; unused bits read zero
// - button latches: bandgap, holds, release, press
// - latch set by event, write-one clears
// - mask one blocks latch from interrupt
// - live bits show current condition state
// - bypassed faults still latch and interrupt
module tlia_top #(
	parameter int LEAD0_CYC = tlia_pkg::LEAD0_CYC,
	parameter int LEAD1_CYC = tlia_pkg::LEAD1_CYC,
	parameter int LEAD2_CYC = tlia_pkg::LEAD2_CYC,
	parameter int LEAD3_CYC = tlia_pkg::LEAD3_CYC
) (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	input wire tlia_pkg::tlia_req_t REQ_I,
	input wire tlia_pkg::tlia_bits_t EVENT_I,
	input wire tlia_pkg::tlia_bits_t LIVE_I,
	input wire logic [3:0] ENABLE_PIN_LEVELS_I,
	input wire logic EARLY_WARN_REQ_I,
	input wire logic [1:0] WARNING_LEAD_TIME_SEL_I,
	output logic [7:0] RDATA_O,
	output logic IRQ_OUT_N_O,
	output logic IRQ_OUT_N_OE_O,
	output logic SHUTDOWN_GO_O
);
	tlia_pkg::tlia_state_t s;
	tlia_pkg::tlia_state_t next_s;
	logic [9:0] pend;
	logic [7:0] clr;
	logic [7:0] rd_val;
	logic [22:0] lead;

	// lead time chosen by the nonvolatile setting
	always_comb
	begin
		case (WARNING_LEAD_TIME_SEL_I)
			2'b00: lead = 23'(LEAD0_CYC - 1);
			2'b01: lead = 23'(LEAD1_CYC - 1);
			2'b10: lead = 23'(LEAD2_CYC - 1);
			default: lead = 23'(LEAD3_CYC - 1);
		endcase
	end

	// next state: latches, masks, summary, interrupt, read data, warning timer
	always_comb
	begin
		next_s = s;
		next_s.go = 1'b0;
		pend = '0;
		clr = '0;
		rd_val = '0;
		for (int g = 0; g < tlia_pkg::NUM_GRP; g++)
		begin
			// write-one clear, event set wins over the clear
			clr = (REQ_I.wr && REQ_I.addr == 5'(3 * g)) ? REQ_I.wdata : 8'h00;
			next_s.flag[g] = ((s.flag[g] & ~clr) | EVENT_I.grp[g])
				& tlia_pkg::FLAG_VALID[g];
			if (REQ_I.wr && REQ_I.addr == 5'(3 * g + 1))
			begin
				next_s.mask[g] = REQ_I.wdata & tlia_pkg::FLAG_VALID[g];
			end
			// a set mask bit keeps its latch off the interrupt
			pend[g] = |(next_s.flag[g] & ~next_s.mask[g]);
			if (REQ_I.addr == 5'(3 * g))
			begin
				rd_val = s.flag[g];
			end
			else if (REQ_I.addr == 5'(3 * g + 1))
			begin
				rd_val = s.mask[g];
			end
			else if (REQ_I.addr == 5'(3 * g + 2))
			begin
				rd_val = LIVE_I.grp[g] & tlia_pkg::LIVE_VALID[g];
			end
		end
		if (REQ_I.addr == tlia_pkg::IDX_ENABLE_PINS)
		begin
			rd_val = {4'h0, ENABLE_PIN_LEVELS_I} & tlia_pkg::ENABLE_PIN_VALID;
		end
		else if (REQ_I.addr == tlia_pkg::IDX_SUMMARY)
		begin
			rd_val = s.summary;
		end
		// summary follows the groups, so clearing latches clears it
		next_s.summary[tlia_pkg::SUM_GENERAL] = pend[tlia_pkg::GRP_GENERAL];
		next_s.summary[tlia_pkg::SUM_SECOND] = pend[tlia_pkg::GRP_TEMP];
		next_s.summary[tlia_pkg::SUM_MODE] = pend[tlia_pkg::GRP_MODE];
		next_s.summary[tlia_pkg::SUM_OC] = pend[tlia_pkg::GRP_CONV_OC]
			| pend[tlia_pkg::GRP_LIN_OC];
		next_s.summary[tlia_pkg::SUM_UV] = pend[tlia_pkg::GRP_CONV_UV]
			| pend[tlia_pkg::GRP_LIN_UV];
		next_s.summary[tlia_pkg::SUM_OV] = pend[tlia_pkg::GRP_CONV_OV]
			| pend[tlia_pkg::GRP_LIN_OV];
		next_s.summary[tlia_pkg::SUM_BUTTON] = pend[tlia_pkg::GRP_BUTTON];
		// early warning stays flagged until reset, timer then fires shutdown
		next_s.summary[tlia_pkg::SUM_WARN] = s.summary[tlia_pkg::SUM_WARN];
		if (s.warn_run)
		begin
			if (s.warn_cnt == tlia_pkg::CNT_RESET)
			begin
				next_s.go = 1'b1;
				next_s.warn_run = 1'b0;
			end
			else
			begin
				next_s.warn_cnt = s.warn_cnt - 23'h00_0001;
			end
		end
		else if (EARLY_WARN_REQ_I && !s.summary[tlia_pkg::SUM_WARN])
		begin
			next_s.warn_run = 1'b1;
			next_s.warn_cnt = lead;
			next_s.summary[tlia_pkg::SUM_WARN] = 1'b1;
		end
		// interrupt held low while any summary bit stands
		next_s.irq_n = ~(|next_s.summary);
		next_s.irq_oe = |next_s.summary; // open-drain enable gets its own flop
		next_s.rdata = REQ_I.rd ? rd_val : s.rdata;
	end

	// state register; writes to read-only addresses touch nothing
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			for (int g = 0; g < tlia_pkg::NUM_GRP; g++)
			begin
				s.flag[g] <= tlia_pkg::FLAG_RESET;
				s.mask[g] <= tlia_pkg::MASK_RESET & tlia_pkg::FLAG_VALID[g];
			end
			s.summary <= 8'h00;
			s.irq_n <= 1'b1;
			s.irq_oe <= 1'b0;
			s.rdata <= 8'h00;
			s.warn_run <= 1'b0;
			s.warn_cnt <= tlia_pkg::CNT_RESET;
			s.go <= 1'b0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// outputs straight from flops
	assign RDATA_O = s.rdata;
	assign IRQ_OUT_N_O = s.irq_n;
	assign IRQ_OUT_N_OE_O = s.irq_oe;
	assign SHUTDOWN_GO_O = s.go;

	// checks
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RST_B_I);

	// pending view per group, rebuilt from stored latches and masks for the checks
	logic [9:0] grp_open;
	always_comb
	begin
		for (int g = 0; g < tlia_pkg::NUM_GRP; g++)
		begin
			grp_open[g] = |(s.flag[g] & ~s.mask[g]);
		end
	end

	// interrupt pin and its enable follow the summary register
	a_irq_matches_summary: assert property (IRQ_OUT_N_O == ~(|s.summary))
		else $error("interrupt pin disagrees with summary");
	a_oe_when_low: assert property (IRQ_OUT_N_OE_O == ~IRQ_OUT_N_O)
		else $error("open-drain enable wrong");
	a_oe_from_summary: assert property (
		IRQ_OUT_N_OE_O == (|s.summary))
		else $error("open-drain enable disagrees with summary");
	a_irq_from_latches: assert property (
		IRQ_OUT_N_O == !((|grp_open) || s.summary[tlia_pkg::SUM_WARN]))
		else $error("interrupt pin disagrees with latches");

	// latch set and write-one clear
	a_set_beats_clear: assert property (
		REQ_I.wr && REQ_I.addr == 5'h00 && REQ_I.wdata[0] && EVENT_I.grp[0][0]
		|=> s.flag[0][0])
		else $error("event lost under clear");
	a_w1c_clears: assert property (
		REQ_I.wr && REQ_I.addr == 5'h1B && REQ_I.wdata[1] && !EVENT_I.grp[9][1]
		|=> !s.flag[9][1])
		else $error("write one did not clear latch");
	a_mode_w1c_clears: assert property (
		REQ_I.wr && REQ_I.addr == 5'h06 && REQ_I.wdata[6] && !EVENT_I.grp[2][6]
		|=> !s.flag[2][6])
		else $error("write one did not clear mode latch");
	a_zero_keeps: assert property (
		REQ_I.wr && REQ_I.addr == 5'h03 && !REQ_I.wdata[2] && s.flag[1][2]
		|=> s.flag[1][2])
		else $error("write zero changed latch");
	a_flag_hold: assert property (
		!REQ_I.wr && EVENT_I.grp[7] == 8'h00 |=> $stable(s.flag[7]))
		else $error("latch changed with no event or write");
	a_event_sets: assert property (
		EVENT_I.grp[3][0] |=> s.flag[3][0])
		else $error("event did not set its latch");
	a_masked_latches: assert property (
		EVENT_I.grp[5][1] && s.mask[5][1] |=> s.flag[5][1])
		else $error("masked event not latched");
	a_bandgap_latch: assert property (
		EVENT_I.grp[9][7] |=> s.flag[9][7])
		else $error("bandgap monitor event not latched");
	a_press_latch: assert property (
		EVENT_I.grp[9][0] |=> s.flag[9][0])
		else $error("button press event not latched");

	// masks
	a_mask_blocks: assert property (
		(s.flag[2] & ~s.mask[2]) == 8'h00 |-> !s.summary[tlia_pkg::SUM_MODE])
		else $error("masked latch raised summary");
	a_button_all_masked: assert property (
		&s.mask[tlia_pkg::GRP_BUTTON] |-> !s.summary[tlia_pkg::SUM_BUTTON])
		else $error("fully masked group raised summary");
	a_mask_write: assert property (
		REQ_I.wr && REQ_I.addr == 5'h04 |=> s.mask[1] == $past(REQ_I.wdata))
		else $error("mask write not stored");
	a_mask_hold: assert property (
		!REQ_I.wr |=> $stable(s.mask))
		else $error("mask changed without a write");

	// summary bits, one per group or pair of groups
	a_general_bit: assert property (
		s.summary[0] == |(s.flag[0] & ~s.mask[0]))
		else $error("general summary wrong");
	a_second_bit: assert property (
		s.summary[tlia_pkg::SUM_SECOND] == grp_open[tlia_pkg::GRP_TEMP])
		else $error("second general summary wrong");
	a_mode_bit: assert property (
		s.summary[tlia_pkg::SUM_MODE] == grp_open[tlia_pkg::GRP_MODE])
		else $error("mode summary wrong");
	a_oc_or_groups: assert property (
		s.summary[tlia_pkg::SUM_OC] ==
		(|(s.flag[3] & ~s.mask[3]) || |(s.flag[4] & ~s.mask[4])))
		else $error("overcurrent summary wrong");
	a_uv_or_groups: assert property (
		s.summary[tlia_pkg::SUM_UV] ==
		(grp_open[tlia_pkg::GRP_CONV_UV] || grp_open[tlia_pkg::GRP_LIN_UV]))
		else $error("undervoltage summary wrong");
	a_ov_or_groups: assert property (
		s.summary[tlia_pkg::SUM_OV] ==
		(grp_open[tlia_pkg::GRP_CONV_OV] || grp_open[tlia_pkg::GRP_LIN_OV]))
		else $error("overvoltage summary wrong");
	a_button_bit: assert property (
		s.summary[tlia_pkg::SUM_BUTTON] == grp_open[tlia_pkg::GRP_BUTTON])
		else $error("button summary wrong");
	a_needs_latch: assert property (
		s.summary[6:0] != 7'h00 |-> (|grp_open))
		else $error("summary set with no open latch");
	a_self_clear: assert property (
		grp_open == 10'h000 |-> s.summary[6:0] == 7'h00)
		else $error("summary stayed after latches cleared");

	// unused positions stay zero
	a_unused_zero: assert property (
		(s.flag[4] & 8'hFE) == 8'h00)
		else $error("unused latch bit set");
	a_unused_mode: assert property (
		(s.flag[2] & 8'hBC) == 8'h00)
		else $error("unused mode latch bit set");
	a_unused_mask: assert property (
		(s.mask[0] & 8'h04) == 8'h00)
		else $error("unused mask bit set");
	a_unused_live: assert property (
		REQ_I.rd && REQ_I.addr == 5'h08 |=> RDATA_O == 8'h00)
		else $error("absent live register read nonzero");

	// register reads
	a_live_read: assert property (
		REQ_I.rd && REQ_I.addr == 5'h1D
		|=> RDATA_O == ($past(LIVE_I.grp[9]) & 8'h81))
		else $error("live read wrong");
	a_temp_live_read: assert property (
		REQ_I.rd && REQ_I.addr == 5'h05 |=> RDATA_O == $past(LIVE_I.grp[1]))
		else $error("temperature live read wrong");
	a_general_live_read: assert property (
		REQ_I.rd && REQ_I.addr == 5'h02
		|=> RDATA_O == ($past(LIVE_I.grp[0]) & 8'h03))
		else $error("general live read wrong");
	a_pins_read: assert property (
		REQ_I.rd && REQ_I.addr == tlia_pkg::IDX_ENABLE_PINS
		|=> RDATA_O == {4'h0, $past(ENABLE_PIN_LEVELS_I)})
		else $error("enable pin read wrong");
	a_flag_read: assert property (
		REQ_I.rd && REQ_I.addr == 5'h00 |=> RDATA_O == $past(s.flag[0]))
		else $error("latch read wrong");
	a_summary_read: assert property (
		REQ_I.rd && REQ_I.addr == tlia_pkg::IDX_SUMMARY |=> RDATA_O == $past(s.summary))
		else $error("summary read wrong");
	a_read_holds: assert property (
		!REQ_I.rd |=> $stable(RDATA_O))
		else $error("read data changed without a read");

	// read-only registers ignore writes
	a_summary_ro: assert property (
		REQ_I.wr && REQ_I.addr == tlia_pkg::IDX_SUMMARY && !EARLY_WARN_REQ_I
		&& EVENT_I.grp == '0 |=> $stable(s.flag) && $stable(IRQ_OUT_N_O))
		else $error("summary write had effect");
	a_pins_ro: assert property (
		REQ_I.wr && REQ_I.addr == tlia_pkg::IDX_ENABLE_PINS |=> $stable(s.mask))
		else $error("enable pin write had effect");
	a_live_ro: assert property (
		REQ_I.wr && REQ_I.addr == 5'h1D |=> $stable(s.mask))
		else $error("live write had effect");

	// early warning flag and shutdown timer
	a_warn_flag: assert property (
		EARLY_WARN_REQ_I && !s.summary[7] |=> s.summary[7] && s.warn_run)
		else $error("early warning not flagged");
	a_warn_sticks: assert property (
		s.summary[tlia_pkg::SUM_WARN] |=> s.summary[tlia_pkg::SUM_WARN])
		else $error("early warning flag dropped");
	a_warn_from_request: assert property (
		$rose(s.summary[tlia_pkg::SUM_WARN]) |-> $past(EARLY_WARN_REQ_I))
		else $error("early warning flag without request");
	a_warn_once: assert property (
		EARLY_WARN_REQ_I && s.summary[7] && !s.warn_run |=> !s.warn_run)
		else $error("second warning request restarted timer");
	a_lead_sel_zero: assert property (
		EARLY_WARN_REQ_I && !s.summary[7] && WARNING_LEAD_TIME_SEL_I == 2'b00
		|=> s.warn_cnt == 23'(LEAD0_CYC - 1))
		else $error("lead time zero not loaded");
	a_lead_sel_one: assert property (
		EARLY_WARN_REQ_I && !s.summary[7] && WARNING_LEAD_TIME_SEL_I == 2'b01
		|=> s.warn_cnt == 23'(LEAD1_CYC - 1))
		else $error("lead time one not loaded");
	a_lead_sel_two: assert property (
		EARLY_WARN_REQ_I && !s.summary[7] && WARNING_LEAD_TIME_SEL_I == 2'b10
		|=> s.warn_cnt == 23'(LEAD2_CYC - 1))
		else $error("lead time two not loaded");
	a_lead_sel_three: assert property (
		EARLY_WARN_REQ_I && !s.summary[7] && WARNING_LEAD_TIME_SEL_I == 2'b11
		|=> s.warn_cnt == 23'(LEAD3_CYC - 1))
		else $error("lead time three not loaded");
	a_warn_count: assert property (
		s.warn_run && s.warn_cnt != tlia_pkg::CNT_RESET
		|=> s.warn_cnt == $past(s.warn_cnt) - 23'h00_0001)
		else $error("lead timer did not count down");
	a_go_at_end: assert property (
		s.warn_run && s.warn_cnt == tlia_pkg::CNT_RESET |=> SHUTDOWN_GO_O && !s.warn_run)
		else $error("shutdown not fired at end of lead");
	a_go_one_cycle: assert property (
		SHUTDOWN_GO_O |=> !SHUTDOWN_GO_O)
		else $error("shutdown pulse too long");
	a_go_needs_warn: assert property (
		SHUTDOWN_GO_O |-> s.summary[tlia_pkg::SUM_WARN])
		else $error("shutdown without early warning");

	// main scenarios
	c_irq_assert: cover property ($fell(IRQ_OUT_N_O));
	c_irq_release: cover property ($rose(IRQ_OUT_N_O));
	c_set_and_clear: cover property (
		REQ_I.wr && REQ_I.addr == 5'h00 && REQ_I.wdata[0] && EVENT_I.grp[0][0]);
	c_shutdown: cover property (SHUTDOWN_GO_O);
	c_warn_taken: cover property (EARLY_WARN_REQ_I && !s.summary[tlia_pkg::SUM_WARN]);
endmodule : tlia_top
`default_nettype wire
